// >>> include/txupc_regs.vh
// Register map, field positions, reset values and timing counts of the
// transmit control slice. Definitions only; included by the top module.
`ifndef TXUPC_REGS_VH
`define TXUPC_REGS_VH
`define TXUPC_ADDR_W 16
`define TXUPC_OFF_TRUNC_LO 16'h4300
`define TXUPC_OFF_TRUNC_HI 16'h4304
`define TXUPC_OFF_PRE_SEL 16'h4400
`define TXUPC_OFF_FLOW_REQ 16'h4500
`define TXUPC_OFF_STOP_VAL 16'h4504
`define TXUPC_OFF_FLOW_EN 16'h4508
`define TXUPC_RST_PRE_SEL 1'h0
`define TXUPC_RST_FLOW_REQ 2'h0
`define TXUPC_RST_STOP_VAL 16'h0000
`define TXUPC_RST_FLOW_EN 1'h1
`define TXUPC_BIT_PASSTHRU 0
`define TXUPC_BIT_XON 0
`define TXUPC_BIT_XOFF 1
`define TXUPC_BIT_FLOW_EN 0
`define TXUPC_CNT_W 36
`define TXUPC_HI_W 4
`define TXUPC_STOP_W 16
`define TXUPC_PRE_BYTE 8'h55
`define TXUPC_SFD_BYTE 8'hD5
`define TXUPC_PRE_LEN 6'h08
`define TXUPC_CTL_TYPE_HI 8'h88
`define TXUPC_CTL_TYPE_LO 8'h08
`define TXUPC_PAUSE_OP_LO 8'h01
`define TXUPC_PAUSE_LEN 6'h3C
`define TXUPC_UFL_LIMIT 3'h4
`define TXUPC_SRC_MAC 48'h020000000001
`endif

// >>> rtl/txupc_top.v
// Transmit control slice: underflow truncation counter, client preamble
// passthrough and XON/XOFF pause frame generator, APB register slave.
// Assumes client, PHY and APB all run on pclk; PHY takes a byte per cycle.
`timescale 1ns/1ns
`default_nettype none
`include "txupc_regs.vh"

module txupc_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_q;
    reg [AW:0] rd_q;
    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty = (wr_q == rd_q);
    wire push = ce && in_valid && !full;
    wire pop = ce && out_ready && !empty;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_q[AW-1:0]];

    always @(posedge pclk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

module txupc_top (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire cl_valid,
    output reg cl_ready,
    input wire [7:0] cl_data,
    input wire cl_last,
    output reg [7:0] phy_data,
    output reg phy_valid,
    output reg phy_sof,
    output reg phy_eof,
    output reg phy_err,
    output reg preamble_passthru
);
    localparam S_IDLE = 3'h0;
    localparam S_PRE = 3'h1;
    localparam S_DATA = 3'h2;
    localparam S_PAUSE = 3'h3;
    localparam S_DROP = 3'h4;

    reg [`TXUPC_CNT_W-1:0] trunc_q;
    reg pre_sel_q;
    reg [1:0] flow_req_q;
    reg [`TXUPC_STOP_W-1:0] stop_val_q;
    reg flow_en_q;
    reg pause_pend_q;
    reg [`TXUPC_STOP_W-1:0] pause_time_q;
    reg [2:0] state_q;
    // Seven bits: a pause frame runs to byte 67 including preamble
    reg [6:0] idx_q;
    reg [2:0] ufl_q;
    reg sof_pend_q;

    wire f_valid;
    wire f_ready;
    wire [8:0] f_data;
    wire f_in_ready;

    // Back-pressure reaches the client through the registered ready
    txupc_fifo #(.WIDTH(9), .DEPTH(32), .AW(5)) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .in_valid(cl_valid && cl_ready),
        .in_ready(f_in_ready),
        .in_data({cl_last, cl_data}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // APB: access phase takes two cycles, pready is a flop
    wire acc = psel && penable && pready;
    // First access-phase cycle; the answer is launched here
    wire acc_first = psel && penable && !pready;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire hit = (paddr == `TXUPC_OFF_TRUNC_LO) ||
               (paddr == `TXUPC_OFF_TRUNC_HI) ||
               (paddr == `TXUPC_OFF_PRE_SEL) ||
               (paddr == `TXUPC_OFF_FLOW_REQ) ||
               (paddr == `TXUPC_OFF_STOP_VAL) ||
               (paddr == `TXUPC_OFF_FLOW_EN);
    wire rd_hi = rd && (paddr == `TXUPC_OFF_TRUNC_HI);

    reg [31:0] rdata_d;
    always @* begin
        case (paddr)
            `TXUPC_OFF_TRUNC_LO: rdata_d = trunc_q[31:0];
            `TXUPC_OFF_TRUNC_HI: rdata_d = {28'h0000000, trunc_q[35:32]};
            `TXUPC_OFF_PRE_SEL: rdata_d = {31'h00000000, pre_sel_q};
            `TXUPC_OFF_FLOW_REQ: rdata_d = {30'h00000000, flow_req_q};
            `TXUPC_OFF_STOP_VAL: rdata_d = {16'h0000, stop_val_q};
            `TXUPC_OFF_FLOW_EN: rdata_d = {31'h00000000, flow_en_q};
            default: rdata_d = 32'h00000000;
        endcase
    end

    // Frame truncated by persistent underflow
    wire ufl_trunc = (state_q == S_DATA) && !f_valid && (ufl_q == `TXUPC_UFL_LIMIT - 3'h1);

    // Pause request decode; both bits or neither sends nothing
    wire req_xon = wr && (paddr == `TXUPC_OFF_FLOW_REQ) &&
                   pwdata[`TXUPC_BIT_XON] && !pwdata[`TXUPC_BIT_XOFF];
    wire req_xoff = wr && (paddr == `TXUPC_OFF_FLOW_REQ) &&
                    pwdata[`TXUPC_BIT_XOFF] && !pwdata[`TXUPC_BIT_XON];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            trunc_q <= 36'h000000000;
            pre_sel_q <= `TXUPC_RST_PRE_SEL;
            flow_req_q <= `TXUPC_RST_FLOW_REQ;
            stop_val_q <= `TXUPC_RST_STOP_VAL;
            flow_en_q <= `TXUPC_RST_FLOW_EN;
            preamble_passthru <= 1'b0;
        end else if (ce) begin
            pready <= acc_first;
            pslverr <= acc_first && !hit;
            prdata <= (acc_first && !pwrite) ? rdata_d : 32'h00000000;
            preamble_passthru <= pre_sel_q;
            // Increment beats the clear in the same cycle
            if (ufl_trunc) begin
                trunc_q <= rd_hi ? 36'h000000001 : trunc_q + 36'h000000001;
            end else if (rd_hi) begin
                trunc_q <= 36'h000000000;
            end
            if (wr) begin
                case (paddr)
                    `TXUPC_OFF_PRE_SEL: pre_sel_q <= pwdata[`TXUPC_BIT_PASSTHRU];
                    `TXUPC_OFF_FLOW_REQ: flow_req_q <= pwdata[1:0];
                    `TXUPC_OFF_STOP_VAL: stop_val_q <= pwdata[15:0];
                    `TXUPC_OFF_FLOW_EN: flow_en_q <= pwdata[`TXUPC_BIT_FLOW_EN];
                    default: flow_en_q <= flow_en_q;
                endcase
            end
        end
    end

    // Source address held at full width so each byte is a plain slice
    localparam [47:0] SRC_MAC = `TXUPC_SRC_MAC;

    // Pause frame byte at index n, preamble excluded
    function [7:0] pause_byte;
        input [5:0] n;
        input [15:0] t;
        begin
            case (n)
                6'h00: pause_byte = 8'h01;
                6'h01: pause_byte = 8'h80;
                6'h02: pause_byte = 8'hC2;
                6'h03: pause_byte = 8'h00;
                6'h04: pause_byte = 8'h00;
                6'h05: pause_byte = 8'h01;
                6'h06: pause_byte = SRC_MAC[47:40];
                6'h07: pause_byte = SRC_MAC[39:32];
                6'h08: pause_byte = SRC_MAC[31:24];
                6'h09: pause_byte = SRC_MAC[23:16];
                6'h0A: pause_byte = SRC_MAC[15:8];
                6'h0B: pause_byte = SRC_MAC[7:0];
                6'h0C: pause_byte = `TXUPC_CTL_TYPE_HI;
                6'h0D: pause_byte = `TXUPC_CTL_TYPE_LO;
                6'h0E: pause_byte = 8'h00;
                6'h0F: pause_byte = `TXUPC_PAUSE_OP_LO;
                6'h10: pause_byte = t[15:8];
                6'h11: pause_byte = t[7:0];
                default: pause_byte = 8'h00;
            endcase
        end
    endfunction

    wire last_pre = (idx_q == {1'b0, `TXUPC_PRE_LEN - 6'h01});
    // Pause preamble shares idx with payload, offset by eight
    wire [6:0] pidx = idx_q - {1'b0, `TXUPC_PRE_LEN};
    localparam [6:0] PAUSE_END = {1'b0, `TXUPC_PRE_LEN} + {1'b0, `TXUPC_PAUSE_LEN} - 7'h01;
    wire pause_last = (idx_q == PAUSE_END);
    assign f_ready = (state_q == S_DATA) || (state_q == S_DROP);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            idx_q <= 7'h00;
            ufl_q <= 3'h0;
            sof_pend_q <= 1'b0;
            pause_pend_q <= 1'b0;
            pause_time_q <= 16'h0000;
            cl_ready <= 1'b0;
            phy_data <= 8'h00;
            phy_valid <= 1'b0;
            phy_sof <= 1'b0;
            phy_eof <= 1'b0;
            phy_err <= 1'b0;
        end else if (ce) begin
            cl_ready <= f_in_ready && !(cl_valid && cl_ready);
            phy_valid <= 1'b0;
            phy_sof <= 1'b0;
            phy_eof <= 1'b0;
            phy_err <= 1'b0;
            // A new request while one waits replaces it
            if (flow_en_q && (req_xon || req_xoff)) begin
                pause_pend_q <= 1'b1;
                pause_time_q <= req_xoff ? stop_val_q : 16'h0000;
            end else if (!flow_en_q) begin
                pause_pend_q <= 1'b0;
            end
            case (state_q)
                S_IDLE: begin
                    idx_q <= 7'h00;
                    ufl_q <= 3'h0;
                    if (pause_pend_q && flow_en_q) begin
                        state_q <= S_PAUSE;
                        pause_pend_q <= 1'b0;
                    end else if (f_valid) begin
                        sof_pend_q <= pre_sel_q;
                        state_q <= pre_sel_q ? S_DATA : S_PRE;
                    end
                end
                S_PRE: begin
                    phy_valid <= 1'b1;
                    phy_sof <= (idx_q == 7'h00);
                    phy_data <= last_pre ? `TXUPC_SFD_BYTE : `TXUPC_PRE_BYTE;
                    idx_q <= idx_q + 7'h01;
                    if (last_pre) begin
                        state_q <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (f_valid) begin
                        ufl_q <= 3'h0;
                        phy_valid <= 1'b1;
                        phy_sof <= sof_pend_q;
                        sof_pend_q <= 1'b0;
                        phy_data <= f_data[7:0];
                        phy_eof <= f_data[8];
                        if (f_data[8]) begin
                            state_q <= S_IDLE;
                        end
                    end else if (ufl_trunc) begin
                        // Cut the frame short and mark it bad
                        phy_valid <= 1'b1;
                        phy_data <= 8'h00;
                        phy_eof <= 1'b1;
                        phy_err <= 1'b1;
                        state_q <= S_DROP;
                    end else begin
                        ufl_q <= ufl_q + 3'h1;
                    end
                end
                S_DROP: begin
                    // Rest of the truncated frame is discarded
                    if (f_valid && f_data[8]) begin
                        state_q <= S_IDLE;
                    end
                end
                S_PAUSE: begin
                    phy_valid <= 1'b1;
                    phy_sof <= (idx_q == 7'h00);
                    idx_q <= idx_q + 7'h01;
                    if (idx_q < {1'b0, `TXUPC_PRE_LEN}) begin
                        phy_data <= last_pre ? `TXUPC_SFD_BYTE : `TXUPC_PRE_BYTE;
                    end else begin
                        phy_data <= pause_byte(pidx[5:0], pause_time_q);
                    end
                    if (pause_last) begin
                        phy_eof <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> tb/txupc_top_monitor.sv
// Checker of the transmit control slice, bound to its top module.
// Assumes one clock; tracks counter, pause requests and PHY byte index.
`timescale 1ns/1ns
`default_nettype none
`include "txupc_regs.vh"
module txupc_top_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cl_valid,
    input wire logic cl_ready,
    input wire logic [7:0] cl_data,
    input wire logic cl_last,
    input wire logic [7:0] phy_data,
    input wire logic phy_valid,
    input wire logic phy_sof,
    input wire logic phy_eof,
    input wire logic phy_err,
    input wire logic preamble_passthru
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd = psel && penable && pready && ce && !pwrite;
    wire wr = psel && penable && pready && ce && pwrite && !pslverr;
    wire req = wr && paddr == `TXUPC_OFF_FLOW_REQ;
    wire one = req && (pwdata[0] ^ pwdata[1]);
    logic [35:0] cnt_q;
    logic [15:0] stop_q, exp_q;
    logic en_q, pend_q, pf_q, busy_q;
    logic [6:0] idx_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 36'h0;
            stop_q <= 16'h0;
            exp_q <= 16'h0;
            {en_q, pend_q, pf_q, busy_q} <= 4'h8;
            idx_q <= 7'h0;
        end else begin
            // Increment wins over the clear of a same-cycle read
            if (rd && paddr == `TXUPC_OFF_TRUNC_HI) cnt_q <= {35'h0, phy_valid && phy_err};
            else if (phy_valid && phy_err) cnt_q <= cnt_q + 36'h1;
            if (wr && paddr == `TXUPC_OFF_STOP_VAL) stop_q <= pwdata[15:0];
            if (wr && paddr == `TXUPC_OFF_FLOW_EN) en_q <= pwdata[0];
            if (phy_valid) idx_q <= phy_sof ? 7'h1 : idx_q + 7'h1;
            if (phy_valid && phy_sof) pf_q <= pend_q;
            if (phy_valid) busy_q <= !phy_eof;
            if (phy_sof || (wr && paddr == `TXUPC_OFF_FLOW_EN && !pwdata[0])) pend_q <= 1'b0;
            if (one && en_q) pend_q <= 1'b1;
            if (one) exp_q <= pwdata[1] ? stop_q : 16'h0;
        end
    end
    sequence s_sof;
        phy_valid && phy_sof;
    endsequence
    property p_byte(k, v);
        phy_valid && !phy_sof && pf_q && idx_q == k |-> phy_data == v;
    endproperty
    AST_CNT_LOW: assert property (rd && paddr == `TXUPC_OFF_TRUNC_LO |-> prdata == cnt_q[31:0])
        else $error("count low word mismatch");
    AST_CNT_HIGH: assert property (rd && paddr == `TXUPC_OFF_TRUNC_HI |-> prdata == {28'h0, cnt_q[35:32]})
        else $error("count high word mismatch");
    AST_TRUNC: assert property (phy_valid && phy_err |-> phy_eof && phy_data == 8'h00)
        else $error("truncated frame end malformed");
    AST_PRE_SOF: assert property (s_sof ##0 !preamble_passthru |-> phy_data == `TXUPC_PRE_BYTE)
        else $error("frame start is not preamble");
    AST_PASSTHRU: assert property (wr && paddr == `TXUPC_OFF_PRE_SEL |-> ##2 preamble_passthru == $past(pwdata[0], 2))
        else $error("passthrough select not applied");
    AST_PAUSE_SENT: assert property (one && en_q && !busy_q |-> ##[1:40] s_sof)
        else $error("pause frame not started");
    AST_BOTH_NONE: assert property (req && pwdata[1:0] == 2'b11 && !busy_q |=> !phy_sof [*8])
        else $error("frame started on both requests");
    AST_DISABLED: assert property (one && !en_q && !busy_q |=> !phy_sof [*8])
        else $error("frame started while disabled");
    AST_TIME_HI: assert property (p_byte(24, exp_q[15:8]))
        else $error("pause time high byte wrong");
    AST_TIME_LO: assert property (p_byte(25, exp_q[7:0]))
        else $error("pause time low byte wrong");
    AST_PAUSE_TYPE: assert property (p_byte(20, `TXUPC_CTL_TYPE_HI))
        else $error("pause type byte wrong");
    AST_PAUSE_LEN: assert property (phy_valid && phy_eof && pf_q && !phy_sof |-> idx_q == 7'd67)
        else $error("pause frame length wrong");
endmodule
bind txupc_top txupc_top_monitor u_mon (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cl_valid(cl_valid), .cl_ready(cl_ready), .cl_data(cl_data), .cl_last(cl_last),
    .phy_data(phy_data), .phy_valid(phy_valid), .phy_sof(phy_sof), .phy_eof(phy_eof),
    .phy_err(phy_err), .preamble_passthru(preamble_passthru)
);
`default_nettype wire

// >>> tb/txupc_client_model.sv
// Client frame source: bytes base, base+1, ... with an optional stall.
// Assumes a byte is taken on valid and ready at a rising edge.
`timescale 1ns/1ns
`default_nettype none
module txupc_client_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic [7:0] len,
    input wire logic [7:0] base,
    input wire logic [7:0] st_at,
    input wire logic [7:0] st_len,
    input wire logic cl_ready,
    output logic cl_valid,
    output logic [7:0] cl_data,
    output logic cl_last,
    output logic busy
);
    logic [7:0] idx_q, wait_q;
    assign cl_valid = busy && wait_q == 8'h00;
    // Idle data inverted so a stale byte never looks live
    assign cl_data = cl_valid ? base + idx_q : ~(base + idx_q);
    assign cl_last = cl_valid && idx_q == len - 8'h01;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            idx_q <= 8'h00;
            wait_q <= 8'h00;
        end else if (go && !busy) begin
            busy <= 1'b1;
            idx_q <= 8'h00;
        end else if (cl_valid && cl_ready) begin
            busy <= !cl_last;
            idx_q <= idx_q + 8'h01;
            if (idx_q + 8'h01 == st_at) wait_q <= st_len;
        end else if (wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
        end
    end
endmodule
`default_nettype wire

// >>> tb/test_tx_underflow_preamble_pause_ctl.sv
// Testbench of the transmit control slice: APB tasks, client model, PHY sink.
// Assumes clock enable held high and one 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none
`include "txupc_regs.vh"
module test_tx_underflow_preamble_pause_ctl;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, e;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, r;
    logic [7:0] len = 8'h1, base = 8'h0, st_at = 8'h0, st_len = 8'h0;
    wire [31:0] prdata;
    wire [7:0] cl_data, phy_data;
    wire pready, pslverr, cl_valid, cl_ready, cl_last, phy_valid, phy_sof, phy_eof, phy_err, pass, busy;
    logic [7:0] rx[$];
    logic [15:0] ra[7] = '{16'h4300, 16'h4304, 16'h4400, 16'h4500, 16'h4504, 16'h4508, 16'h4600};
    logic [31:0] rv[7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
    int bad_count = 0, tests_run = 0, nfr = 0, cyc = 0;
    txupc_top u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cl_valid(cl_valid), .cl_ready(cl_ready), .cl_data(cl_data),
        .cl_last(cl_last), .phy_data(phy_data), .phy_valid(phy_valid), .phy_sof(phy_sof),
        .phy_eof(phy_eof), .phy_err(phy_err), .preamble_passthru(pass));
    txupc_client_model u_cli (.pclk(pclk), .presetn(presetn), .go(go), .len(len), .base(base),
        .st_at(st_at), .st_len(st_len), .cl_ready(cl_ready), .cl_valid(cl_valid),
        .cl_data(cl_data), .cl_last(cl_last), .busy(busy));
    initial forever #5 pclk = ~pclk;
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (phy_valid === 1'b1) begin
            if (phy_sof) rx.delete();
            rx.push_back(phy_data);
            if (phy_eof) nfr <= nfr + 1;
        end
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Request held until pready is seen high at a rising edge; data taken there
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        if (n >= 50) bad_count++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), r, exp);
    endtask
    task automatic send(input logic [7:0] l, b, sa, sl, input int nf);
        int n0, k;
        n0 = nfr;
        k = 0;
        {len, base, st_at, st_len} <= {l, b, sa, sl};
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        while ((nfr < n0 + nf || busy) && k < 600) begin
            @(posedge pclk);
            k++;
        end
        chk("frame done", k < 600, 32'h1);
    endtask
    task automatic flow(input logic [1:0] c, input logic [15:0] t, input int nf);
        int n0, k;
        n0 = nfr;
        k = 0;
        apb(1'b1, `TXUPC_OFF_FLOW_REQ, {30'h0, c});
        while (k < 150 && (nf == 0 || nfr == n0)) begin
            @(posedge pclk);
            k++;
        end
        chk("pause count", nfr - n0, nf);
        if (nf != 0) chk("pause len", rx.size(), 68);
        if (nf != 0) chk("pause time", {rx[24], rx[25]}, t);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) rdc(ra[i], rv[i]);
        chk("unmapped err", e, 1'b1);
        $display("test reset done");
        apb(1'b1, `TXUPC_OFF_STOP_VAL, 32'hFFFFABCD);
        rdc(`TXUPC_OFF_STOP_VAL, 32'h0000ABCD);
        send(8'd10, 8'h10, 8'h0, 8'h0, 1);
        chk("normal len", rx.size(), 18);
        for (int i = 0; i < 18; i++) chk("normal byte", rx[i], i < 7 ? 8'h55 : i == 7 ? 8'hD5 : 8 + i);
        apb(1'b1, `TXUPC_OFF_PRE_SEL, 32'h1);
        rdc(`TXUPC_OFF_PRE_SEL, 32'h1);
        send(8'd12, 8'hA0, 8'h0, 8'h0, 1);
        chk("pass len", rx.size(), 12);
        for (int i = 0; i < 12; i++) chk("pass byte", rx[i], 8'hA0 + i);
        apb(1'b1, `TXUPC_OFF_PRE_SEL, 32'h0);
        $display("test preamble done");
        repeat (2) send(8'd10, 8'h40, 8'h3, 8'd20, 1);
        chk("trunc tail", rx[rx.size() - 1], 32'h0);
        rdc(`TXUPC_OFF_TRUNC_LO, 32'h2);
        rdc(`TXUPC_OFF_TRUNC_LO, 32'h2);
        rdc(`TXUPC_OFF_TRUNC_HI, 32'h0);
        rdc(`TXUPC_OFF_TRUNC_LO, 32'h0);
        $display("test underflow done");
        apb(1'b1, `TXUPC_OFF_STOP_VAL, 32'h1234);
        flow(2'b01, 16'h0000, 1);
        flow(2'b10, 16'h1234, 1);
        flow(2'b11, 16'h0000, 0);
        apb(1'b1, `TXUPC_OFF_FLOW_EN, 32'h0);
        flow(2'b10, 16'h0000, 0);
        apb(1'b1, `TXUPC_OFF_FLOW_EN, 32'h1);
        $display("test pause done");
        // Pause holds the path, so the FIFO fills and refuses client bytes
        apb(1'b1, `TXUPC_OFF_FLOW_REQ, 32'h2);
        send(8'd40, 8'h20, 8'h0, 8'h0, 2);
        chk("queued len", rx.size(), 48);
        chk("queued tail", rx[47], 8'h20 + 39);
        $display("test backpressure done");
        finish_test();
    end
endmodule
`default_nettype wire
